// ==== include/nps_pkg.sv ====
package nps_pkg;
  // ==========================================================
  // command codes
  localparam logic [7:0] CMD_LOAD1 = 8'h80;
  localparam logic [7:0] CMD_DUMMY = 8'h11;
  localparam logic [7:0] CMD_LOAD2 = 8'h81;
  localparam logic [7:0] CMD_PROG = 8'h10;
  localparam logic [7:0] CMD_ESETUP = 8'h60;
  localparam logic [7:0] CMD_ECONF = 8'hd0;
  localparam logic [7:0] CMD_STATUS = 8'h70;
  localparam logic [7:0] CMD_ID = 8'h90;
  localparam logic [7:0] CMD_RESET = 8'hff;
  localparam logic [7:0] ID_ADDR = 8'h00;
  // ==========================================================
  // address, status bit and transfer length layout
  localparam int COL_W = 12;
  localparam int ROW_W = 19;
  localparam int LEN_W = 13;
  localparam int PLANE_BIT = 7;
  localparam int FAIL_BIT = 0;
  localparam int READY_BIT = 6;
  localparam logic [2:0] AIDX_ROW0 = 3'h2;
  localparam logic [2:0] ID_BYTES = 3'h5;
  localparam logic [2:0] ONE_BYTE = 3'h1;
  localparam logic [LEN_W-1:0] PAGE_PAIR_MAX = 13'h1080;
  // ==========================================================
  // timing
  localparam int CLK_NS = 100;
  localparam int POR_NS = 10000;
  localparam int TWB_NS = 100;
  localparam int POR_CYC = (POR_NS + CLK_NS - 1) / CLK_NS;
  localparam int TWB_CYC = (TWB_NS + CLK_NS - 1) / CLK_NS;
  // ==========================================================
  // types
  typedef enum logic [2:0] {OP_PROG2, OP_ERASE1, OP_ERASE2, OP_STATUS, OP_ID,
                            OP_RESET} nps_op_e;
  typedef enum logic [1:0] {K_CMD, K_ADDR, K_WDAT, K_RDAT} nps_kind_e;
  typedef enum logic [2:0] {A_CMD, A_ADDR, A_DATA, A_READ, A_WAIT, A_END} nps_act_e;
  typedef enum logic [1:0] {PL_RAW, PL_LO, PL_HI} nps_plane_e;
endpackage

// ==== include/nps_bus_if.sv ====
`timescale 1ns/100ps
interface nps_bus_if;
  import nps_pkg::*;
  logic req;
  nps_kind_e kind;
  logic [7:0] wbyte;
  logic idle;
  logic done;
  logic [7:0] rbyte;
  modport ctrl (output req, kind, wbyte, input idle, done, rbyte);
  modport eng (input req, kind, wbyte, output idle, done, rbyte);
endinterface

// ==== src/nps_strobe.sv ====
`timescale 1ns/100ps
module nps_strobe (
  // clock and reset
  input wire logic sys_clk,
  input wire logic nrst,
  // sequencer side
  nps_bus_if.eng bus,
  // flash pins
  output logic cle,
  output logic ale,
  output logic we_n,
  output logic output_strobe_n,
  output logic [7:0] io_out,
  output logic io_oe,
  input wire logic [7:0] io_in
);
  import nps_pkg::*;
  // ==========================================================
  // one bus cycle: setup, strobe low, strobe high
  typedef enum logic [1:0] {S_IDLE, S_SETUP, S_LOW, S_HIGH} nps_sst_e;
  nps_sst_e st_r, st_nxt;
  nps_kind_e kind_r, kind_nxt;
  logic [7:0] io_r, io_nxt, rb_r, rb_nxt;
  logic cle_r, cle_nxt, ale_r, ale_nxt, we_r, we_nxt, ostb_r, ostb_nxt, oe_r, oe_nxt;

  always_comb begin
    st_nxt = st_r;
    kind_nxt = kind_r;
    io_nxt = io_r;
    rb_nxt = rb_r;
    cle_nxt = cle_r;
    ale_nxt = ale_r;
    we_nxt = we_r;
    ostb_nxt = ostb_r;
    oe_nxt = oe_r;
    unique case (st_r)
      S_IDLE: begin
        if (bus.req) begin
          st_nxt = S_SETUP;
          kind_nxt = bus.kind;
          io_nxt = bus.wbyte;
          cle_nxt = (bus.kind == K_CMD);
          ale_nxt = (bus.kind == K_ADDR);
          oe_nxt = (bus.kind != K_RDAT);
        end
      end
      S_SETUP: begin
        st_nxt = S_LOW;
        if (kind_r == K_RDAT) begin
          ostb_nxt = 1'b0;
        end else begin
          we_nxt = 1'b0;
        end
      end
      S_LOW: begin
        st_nxt = S_HIGH;
        we_nxt = 1'b1;
        ostb_nxt = 1'b1;
        if (kind_r == K_RDAT) begin
          rb_nxt = io_in;
        end
      end
      S_HIGH: begin
        st_nxt = S_IDLE;
        cle_nxt = 1'b0;
        ale_nxt = 1'b0;
        oe_nxt = 1'b0;
      end
    endcase
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      st_r <= S_IDLE;
      kind_r <= K_CMD;
      io_r <= 8'h00;
      rb_r <= 8'h00;
      cle_r <= 1'b0;
      ale_r <= 1'b0;
      we_r <= 1'b1;
      ostb_r <= 1'b1;
      oe_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      kind_r <= kind_nxt;
      io_r <= io_nxt;
      rb_r <= rb_nxt;
      cle_r <= cle_nxt;
      ale_r <= ale_nxt;
      we_r <= we_nxt;
      ostb_r <= ostb_nxt;
      oe_r <= oe_nxt;
    end
  end

  assign bus.idle = (st_r == S_IDLE);
  assign bus.done = (st_r == S_HIGH);
  assign bus.rbyte = rb_r;
  assign cle = cle_r;
  assign ale = ale_r;
  assign we_n = we_r;
  assign output_strobe_n = ostb_r;
  assign io_out = io_r;
  assign io_oe = oe_r;

  // ==========================================================
  // checks
  latch_excl_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    !(cle && ale)) else $error("both latch enables high");
  write_edge_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    $rose(we_n) |-> output_strobe_n && io_oe && $past(io_oe, 2))
    else $error("bad write cycle");
  read_pulse_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    $fell(output_strobe_n) |-> !cle && !ale && we_n && !io_oe ##1 output_strobe_n)
    else $error("bad read pulse");
endmodule

// ==== src/nps_host.sv ====
`timescale 1ns/100ps
module nps_host #(
  parameter logic [nps_pkg::LEN_W-1:0] PAGE_MAX = nps_pkg::PAGE_PAIR_MAX
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic nrst,
  // operation request
  input wire logic op_valid,
  input wire nps_pkg::nps_op_e op_code,
  input wire logic [nps_pkg::ROW_W-1:0] op_row,
  input wire logic [nps_pkg::COL_W-1:0] op_col,
  input wire logic [nps_pkg::LEN_W-1:0] op_len,
  output logic op_ready,
  // write data stream
  input wire logic [7:0] wr_data,
  input wire logic wr_valid,
  output logic wr_ready,
  // read data and result
  output logic [7:0] rd_data,
  output logic rd_valid,
  output logic op_done,
  output logic [7:0] status_byte,
  output logic op_fail,
  // flash pins
  output logic ce_n,
  output logic cle,
  output logic ale,
  output logic we_n,
  output logic output_strobe_n,
  output logic wp_n,
  output logic [7:0] io_out,
  output logic io_oe,
  input wire logic [7:0] io_in,
  input wire logic rb_n
);
  import nps_pkg::*;
  localparam int PW = $clog2(POR_CYC + 1);

  typedef enum logic [1:0] {M_POR, M_IDLE, M_RUN} nps_mst_e;
  nps_bus_if bus ();

  nps_mst_e st_r, st_nxt;
  nps_op_e op_r, op_nxt;
  logic [ROW_W-1:0] row_r, row_nxt;
  logic [COL_W-1:0] col_r, col_nxt;
  logic [LEN_W-1:0] len_r, len_nxt, cnt_r, cnt_nxt;
  logic [4:0] step_r, step_nxt;
  logic [PW-1:0] por_r, por_nxt;
  logic [7:0] rd_r, rd_nxt, stat_r, stat_nxt;
  logic rdv_r, rdv_nxt, done_r, done_nxt, dummy_r, dummy_nxt;

  // ==========================================================
  // step decode
  nps_act_e act;
  logic [7:0] val;
  logic [2:0] aidx, rlen;
  nps_plane_e plane;

  always_comb begin
    act = A_END;
    val = 8'h00;
    aidx = 3'h0;
    rlen = ONE_BYTE;
    plane = PL_RAW;
    unique case (op_r)
      OP_PROG2: begin
        unique case (step_r)
          5'd0: begin act = A_CMD; val = CMD_LOAD1; end
          5'd1, 5'd2, 5'd3, 5'd4, 5'd5: begin
            act = A_ADDR; aidx = 3'(step_r - 5'd1); plane = PL_LO;
          end
          5'd6, 5'd15: act = A_DATA;
          5'd7: begin act = A_CMD; val = CMD_DUMMY; end
          5'd8, 5'd17: act = A_WAIT;
          5'd9: begin act = A_CMD; val = CMD_LOAD2; end
          5'd10, 5'd11, 5'd12, 5'd13, 5'd14: begin
            act = A_ADDR; aidx = 3'(step_r - 5'd10); plane = PL_HI;
          end
          5'd16: begin act = A_CMD; val = CMD_PROG; end
          5'd18: begin act = A_CMD; val = CMD_STATUS; end
          5'd19: act = A_READ;
          default: act = A_END;
        endcase
      end
      OP_ERASE1: begin
        unique case (step_r)
          5'd0: begin act = A_CMD; val = CMD_ESETUP; end
          5'd1, 5'd2, 5'd3: begin act = A_ADDR; aidx = 3'(step_r + 5'd1); end
          5'd4: begin act = A_CMD; val = CMD_ECONF; end
          5'd5: act = A_WAIT;
          5'd6: begin act = A_CMD; val = CMD_STATUS; end
          5'd7: act = A_READ;
          default: act = A_END;
        endcase
      end
      OP_ERASE2: begin
        unique case (step_r)
          5'd0, 5'd4: begin act = A_CMD; val = CMD_ESETUP; end
          5'd1, 5'd2, 5'd3: begin
            act = A_ADDR; aidx = 3'(step_r + 5'd1); plane = PL_LO;
          end
          5'd5, 5'd6, 5'd7: begin
            act = A_ADDR; aidx = 3'(step_r - 5'd3); plane = PL_HI;
          end
          5'd8: begin act = A_CMD; val = CMD_ECONF; end
          5'd9: act = A_WAIT;
          5'd10: begin act = A_CMD; val = CMD_STATUS; end
          5'd11: act = A_READ;
          default: act = A_END;
        endcase
      end
      OP_STATUS: begin
        unique case (step_r)
          5'd0: begin act = A_CMD; val = CMD_STATUS; end
          5'd1: act = A_READ;
          default: act = A_END;
        endcase
      end
      OP_ID: begin
        unique case (step_r)
          5'd0: begin act = A_CMD; val = CMD_ID; end
          5'd1: begin act = A_ADDR; aidx = 3'h5; end
          5'd2: begin act = A_READ; rlen = ID_BYTES; end
          default: act = A_END;
        endcase
      end
      OP_RESET: begin
        unique case (step_r)
          5'd0: begin act = A_CMD; val = CMD_RESET; end
          5'd1: act = A_WAIT;
          default: act = A_END;
        endcase
      end
      default: act = A_END;
    endcase
  end

  // ==========================================================
  // address byte with plane bit forced
  logic [23:0] row24;
  logic [15:0] col16;
  logic [7:0] abyte;

  always_comb begin
    row24 = 24'(row_r);
    col16 = 16'(col_r);
    if (plane == PL_LO) begin
      row24[PLANE_BIT] = 1'b0;
    end else if (plane == PL_HI) begin
      row24[PLANE_BIT] = 1'b1;
    end
    unique case (aidx)
      3'h0: abyte = col16[7:0];
      3'h1: abyte = col16[15:8];
      3'h2: abyte = row24[7:0];
      3'h3: abyte = row24[15:8];
      3'h4: abyte = row24[23:16];
      default: abyte = ID_ADDR;
    endcase
  end

  // ==========================================================
  // bus requests
  logic bus_act;
  assign bus_act = (act == A_CMD) || (act == A_ADDR) || (act == A_READ) ||
                   ((act == A_DATA) && wr_valid);
  assign bus.req = (st_r == M_RUN) && bus_act && bus.idle;
  assign wr_ready = bus.req && (act == A_DATA);

  always_comb begin
    bus.kind = K_CMD;
    bus.wbyte = val;
    unique case (act)
      A_ADDR: begin bus.kind = K_ADDR; bus.wbyte = abyte; end
      A_DATA: begin bus.kind = K_WDAT; bus.wbyte = wr_data; end
      A_READ: bus.kind = K_RDAT;
      default: bus.kind = K_CMD;
    endcase
  end

  // ==========================================================
  // sequencer
  always_comb begin
    st_nxt = st_r;
    op_nxt = op_r;
    row_nxt = row_r;
    col_nxt = col_r;
    len_nxt = len_r;
    cnt_nxt = cnt_r;
    step_nxt = step_r;
    por_nxt = por_r;
    rd_nxt = rd_r;
    stat_nxt = stat_r;
    rdv_nxt = 1'b0;
    done_nxt = 1'b0;
    dummy_nxt = dummy_r;
    unique case (st_r)
      M_POR: begin
        if (por_r == PW'(POR_CYC)) begin
          st_nxt = M_IDLE;
        end else begin
          por_nxt = por_r + PW'(1);
        end
      end
      M_IDLE: begin
        if (op_valid) begin
          st_nxt = M_RUN;
          op_nxt = op_code;
          row_nxt = op_row;
          col_nxt = op_col;
          len_nxt = (op_len > PAGE_MAX) ? PAGE_MAX : op_len;
          step_nxt = 5'd0;
          cnt_nxt = '0;
          dummy_nxt = 1'b0;
        end
      end
      M_RUN: begin
        unique case (act)
          A_CMD, A_ADDR: begin
            if (bus.done) begin
              step_nxt = step_r + 5'd1;
              if (val == CMD_DUMMY && act == A_CMD) begin
                dummy_nxt = 1'b1;
              end
            end
          end
          A_DATA, A_READ: begin
            if (bus.done) begin
              if (act == A_READ) begin
                rd_nxt = bus.rbyte;
                rdv_nxt = 1'b1;
                if (op_r != OP_ID) begin
                  stat_nxt = bus.rbyte;
                end
              end
              if (cnt_r + LEN_W'(1) >= ((act == A_DATA) ? len_r : LEN_W'(rlen))) begin
                step_nxt = step_r + 5'd1;
                cnt_nxt = '0;
              end else begin
                cnt_nxt = cnt_r + LEN_W'(1);
              end
            end
          end
          A_WAIT: begin
            if (cnt_r < LEN_W'(TWB_CYC)) begin
              cnt_nxt = cnt_r + LEN_W'(1);
            end else if (rb_n) begin
              step_nxt = step_r + 5'd1;
              cnt_nxt = '0;
            end
          end
          default: begin
            st_nxt = M_IDLE;
            done_nxt = 1'b1;
          end
        endcase
      end
      default: st_nxt = M_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      st_r <= M_POR;
      op_r <= OP_STATUS;
      row_r <= '0;
      col_r <= '0;
      len_r <= '0;
      cnt_r <= '0;
      step_r <= 5'd0;
      por_r <= '0;
      rd_r <= 8'h00;
      stat_r <= 8'h00;
      rdv_r <= 1'b0;
      done_r <= 1'b0;
      dummy_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      op_r <= op_nxt;
      row_r <= row_nxt;
      col_r <= col_nxt;
      len_r <= len_nxt;
      cnt_r <= cnt_nxt;
      step_r <= step_nxt;
      por_r <= por_nxt;
      rd_r <= rd_nxt;
      stat_r <= stat_nxt;
      rdv_r <= rdv_nxt;
      done_r <= done_nxt;
      dummy_r <= dummy_nxt;
    end
  end

  assign op_ready = (st_r == M_IDLE);
  assign rd_data = rd_r;
  assign rd_valid = rdv_r;
  assign op_done = done_r;
  assign status_byte = stat_r;
  assign op_fail = stat_r[FAIL_BIT];
  assign ce_n = (st_r != M_RUN);
  assign wp_n = (st_r != M_POR);

  nps_strobe u_strobe (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .bus(bus),
    .cle(cle),
    .ale(ale),
    .we_n(we_n),
    .output_strobe_n(output_strobe_n),
    .io_out(io_out),
    .io_oe(io_oe),
    .io_in(io_in)
  );

  // ==========================================================
  // checks
  por_quiet_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    (st_r == M_POR) |-> !bus.req && !wp_n) else $error("activity during power-up");
  busy_quiet_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    (st_r == M_RUN && act == A_WAIT && !rb_n) |=> (act == A_WAIT) && !bus.req)
    else $error("command while busy");
  plane_low_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    (bus.req && op_r == OP_PROG2 && step_r == 5'd3) |-> !bus.wbyte[PLANE_BIT])
    else $error("first page not in first plane");
  plane_high_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    (bus.req && op_r == OP_PROG2 && step_r == 5'd12) |-> bus.wbyte[PLANE_BIT])
    else $error("second page not in second plane");
  second_load_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    (bus.req && bus.kind == K_CMD && bus.wbyte == CMD_LOAD2) |-> dummy_r && $past(rb_n))
    else $error("81h without completed 11h");
endmodule

// ==== verif/nps_flash_model.sv ====
`timescale 1ns/100ps
module nps_flash_model #(
  parameter logic [7:0] MAKER_ID = 8'h5a, // arbitrary value
  parameter int DBSY_NS = 1000,
  parameter int WORK_NS = 3000,
  parameter int RST_NS = 500
) (
  // flash pins
  input wire logic ce_n,
  input wire logic cle,
  input wire logic ale,
  input wire logic we_n,
  input wire logic output_strobe_n,
  input wire logic wp_n,
  input wire logic [7:0] din,
  output logic [7:0] dout,
  output logic rb_n,
  // fault control
  input wire logic fail_next
);
  // ==========================================================
  // state
  logic [7:0] ids [5];
  logic [7:0] a [5];
  logic [7:0] last;
  logic [11:0] blk [2];
  logic p1, p2, fail, in_rst, busy;
  int seq, acnt, load, progs, erases, dbsy, idx, mode;
  realtime busy_end;
  wire [7:0] stat = {wp_n, ~busy, 5'h00, fail};
  initial begin
    ids = '{MAKER_ID, 8'h3c, 8'h11, 8'h22, 8'h33}; // arbitrary values
    {p1, p2, fail, in_rst, busy} = '0;
    {seq, acnt, load, progs, erases, dbsy, idx, mode} = '0;
    last = 8'h00;
    busy_end = 0;
  end
  task automatic go(input int ns);
    busy_end = $realtime + ns;
    busy = 1'b1;
  endtask
  // busy is re-evaluated off the clock edges to keep the ready line race free
  initial #5 forever #10 busy = $realtime < busy_end;
  // open drain with pull-up: low only while busy
  assign rb_n = busy ? 1'b0 : 1'b1;
  // ==========================================================
  // write cycles
  always @(posedge we_n) if (!ce_n && output_strobe_n) begin
    if (cle && !ale) begin
      if (!busy || din == 8'h70 || din == 8'hff) begin
        if (din != 8'hff) in_rst = 1'b0;
        case (din)
          8'hff: if (!in_rst) begin
            in_rst = 1'b1; seq = 0; mode = 0; fail = 1'b0; go(RST_NS);
          end
          8'h70: mode = 1;
          8'h90: begin mode = 2; idx = 0; end
          8'h80: begin seq = 1; acnt = 0; load = 0; {p1, p2} = 2'b10; end
          8'h11: if (seq == 1) begin seq = 2; dbsy++; go(DBSY_NS); end
          8'h81: begin seq = (seq == 2) ? 3 : 0; acnt = 0; end
          8'h10: begin
            if (seq == 3 && wp_n) begin progs++; fail = fail_next; go(WORK_NS); end
            seq = 0;
          end
          8'h60: begin seq = (seq == 4 && acnt == 3) ? 5 : 4; acnt = 0; end
          8'hd0: begin
            if (seq >= 4 && wp_n) begin erases++; fail = fail_next; go(WORK_NS); end
            seq = 0;
          end
          default: seq = 0;
        endcase
      end
    end else if (ale && !cle) begin
      if (acnt < 5) a[acnt] = din;
      acnt++;
      if (seq == 1 && acnt == 3) p1 = din[7];
      if (seq == 3 && acnt == 3) p2 = din[7];
      if (seq >= 4 && acnt == 3) blk[seq-4] = {din[2:0], a[1], a[0][7]};
    end else if (!cle && !ale && (seq == 1 || seq == 3) && load < 4224) begin
      load++;
    end
  end
  // ==========================================================
  // read cycles
  always @(posedge output_strobe_n) if (!ce_n) begin
    last = (mode == 2) ? ids[idx] : stat;
    if (mode == 2 && idx < 4) idx++;
  end
  // released bus shows the inverse of the last byte
  assign dout = (!ce_n && !output_strobe_n && we_n && !cle && !ale) ?
                (mode == 2 ? ids[idx] : stat) : ~last;
endmodule

// ==== verif/nps_host_bench.sv ====
`timescale 1ns/100ps
module nps_host_bench;
  import nps_pkg::*;
  logic sys_clk = 0, nrst = 0, op_valid = 0, wr_valid = 0, fail_next = 0;
  nps_op_e op_code = OP_STATUS;
  logic [18:0] op_row = '0;
  logic [11:0] op_col = '0;
  logic [12:0] op_len = 13'h0003;
  logic [7:0] wr_data = 8'h00, wcnt = 8'h00, rd_data, status_byte, io_out, io_in;
  logic op_ready, wr_ready, rd_valid, op_done, op_fail;
  logic ce_n, cle, ale, we_n, output_strobe_n, wp_n, io_oe, rb_n;
  int miscompares = 0, compares = 0, cyc = 0, rb_lo = 0;
  logic [7:0] rq [$];
  always #50 sys_clk = ~sys_clk;
  nps_host dut (.sys_clk, .nrst, .op_valid, .op_code, .op_row, .op_col, .op_len,
    .op_ready, .wr_data, .wr_valid, .wr_ready, .rd_data, .rd_valid, .op_done,
    .status_byte, .op_fail, .ce_n, .cle, .ale, .we_n, .output_strobe_n, .wp_n, .io_out,
    .io_oe, .io_in, .rb_n);
  nps_flash_model flash (.ce_n, .cle, .ale, .we_n, .output_strobe_n, .wp_n, .din(io_out),
    .dout(io_in), .rb_n, .fail_next);
  // ==========================================================
  // monitors and write stream
  always @(posedge sys_clk) begin
    cyc++;
    if (rd_valid === 1'b1) rq.push_back(rd_data);
    if (rb_n === 1'b0) rb_lo++;
    if (wr_valid && wr_ready) wcnt <= wcnt + 8'h01;
    if (cyc == 20000) begin
      miscompares++;
      tally_and_finish();
    end
  end
  always @(negedge sys_clk) wr_data <= wcnt ^ 8'h5c;
  // ==========================================================
  // helpers
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk1(input logic got, input logic exp);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic run_op(input nps_op_e c, input logic [18:0] r);
    int k;
    k = 0;
    @(negedge sys_clk);
    while (op_ready !== 1'b1 && k < 2000) begin @(negedge sys_clk); k++; end
    rq = {};
    op_code = c;
    op_row = r;
    op_valid = 1'b1;
    @(negedge sys_clk);
    op_valid = 1'b0;
    k = 0;
    while (op_done !== 1'b1 && k < 5000) begin @(posedge sys_clk); #1; k++; end
    if (k >= 5000) miscompares++;
  endtask
  task automatic tally_and_finish();
    $display("compares=%0d miscompares=%0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // ==========================================================
  // scenarios
  task automatic t_power();
    int k;
    repeat (50) @(negedge sys_clk);
    chk1(wp_n, 1'b0);
    chk1(op_ready, 1'b0);
    k = 50;
    while (op_ready !== 1'b1 && k < 300) begin @(negedge sys_clk); k++; end
    chk1(k >= 100, 1'b1);
    chk1(wp_n, 1'b1);
  endtask
  task automatic t_status(input logic [7:0] exp);
    run_op(OP_STATUS, '0);
    chk8(8'(rq.size()), 8'h01);
    chk8(rq[0], exp);
    chk8(status_byte, exp);
  endtask
  task automatic t_id();
    run_op(OP_ID, '0);
    chk8(8'(rq.size()), 8'h05);
    for (int i = 0; i < 5; i++) chk8(rq[i], flash.ids[i]);
  endtask
  task automatic t_prog(input logic f);
    int p0, d0;
    logic [7:0] w0;
    p0 = flash.progs;
    d0 = flash.dbsy;
    w0 = wcnt;
    fail_next = f;
    run_op(OP_PROG2, 19'h123c5);
    chk8(wcnt - w0, 8'h06);
    chk8(8'(flash.load), 8'h06);
    chk1(flash.p1, 1'b0);
    chk1(flash.p2, 1'b1);
    chk8(8'(flash.dbsy - d0), 8'h01);
    chk8(8'(flash.progs - p0), 8'h01);
    chk8(rq[0], {2'b11, 5'h00, f});
    chk1(op_fail, f);
    fail_next = 1'b0;
  endtask
  task automatic t_erase(input nps_op_e c);
    int e0;
    e0 = flash.erases;
    run_op(c, 19'h5a5ff);
    chk8(8'(flash.erases - e0), 8'h01);
    if (c == OP_ERASE1) begin
      chk8(flash.blk[0][7:0], 8'h4b);
      chk8({4'h0, flash.blk[0][11:8]}, 8'h0b);
    end else begin
      chk8(flash.blk[0][7:0], 8'h4a);
      chk8(flash.blk[1][7:0], 8'h4b);
    end
    chk8(rq[0], 8'hc0);
  endtask
  task automatic t_reset();
    int r0;
    r0 = rb_lo;
    run_op(OP_RESET, '0);
    chk1(flash.in_rst, 1'b1);
    chk1(rb_lo > r0, 1'b1);
    t_status(8'hc0);
  endtask
  // ==========================================================
  // main sequence
  initial begin
    repeat (12) @(negedge sys_clk);
    chk1(ce_n, 1'b1);
    nrst = 1'b1;
    wr_valid = 1'b1;
    t_power();
    t_status(8'hc0);
    t_id();
    t_prog(1'b0);
    t_prog(1'b1);
    t_reset();
    t_erase(OP_ERASE1);
    t_erase(OP_ERASE2);
    tally_and_finish();
  end
endmodule
